// File: design/rzf_top.sv
// Purpose: Baseline suppression and weighted averaging of signed readings
// Assumes: Readings arrive one per conversion on REF_CLK, APB for software
// Notes:   Resolution 0 is the highest, each step divides counts by ten
// Function
// R1: Enabling zero captures the shown reading; later outputs are input minus it.
// R2: Each function keeps its own baseline across function changes.
// R3: Baseline is stored in absolute units and rescaled on every range.
// R4: Baselines up to full scale, 2200000 counts at top resolution, accepted.
// R5: Display limit 2200000 counts without zero, 4400000 with zero.
// R6: Every count limit is divided by 10, 100, 1000 per resolution step.
// R7: Input beyond range full scale is always overrange.
// R8: Baseline larger than the selected range gives overrange.
// R9: New baseline only after off then on; first triggered conversion latched.
// R10: Each captured baseline is also copied to the zero-program store.
// R11: Zero off clears only the selected function's baseline.
// R12: Zero indicator blinks until an on-scale reading is captured.
// R13: Hazard marker added when the input is 40V or more.
// R14: Front filter weight 1 to 99, default 10, one per function.
// R15: Front filter weights survive function changes.
// R16: New average is old average plus difference divided by weight.
// R17: Reading outside the window replaces the average and restarts it.
// R18: Front window 10000 counts, scaled down per resolution step.
// R19: Filter indicator blinks three time constants after trigger, one on break; the code blinks on break only outside single trigger mode.
// R20: Internal filter on at reset, software switchable, top two resolutions only.
// R21: Single-trigger output withheld until filters settle, three time constants.
// R22: With both filters active the time constant is the weight sum.
// R23: Wide signed fixed-point arithmetic so subtraction and averaging never wrap.
//
// Added by the designer: the APB register port and the placing of the registers.
`timescale 1ns/1ps
module rzf_top
	import rzf_pkg::*;
#(
	parameter int NFUNC     = 8,
	parameter int NRANGE    = 7,
	parameter int BLINK_CYC = RZF_BLINK_CYC
) (
	input  wire logic        REF_CLK,
	input  wire logic        SRST,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	input  wire logic        TRIG,
	input  wire logic        SAMPLE_VALID,
	input  wire logic [31:0] SAMPLE_DATA,
	input  wire logic        SAMPLE_OVR,
	input  wire logic        SAMPLE_HV,
	output logic             RES_VALID,
	output rzf_result_t      RES_DATA,
	output logic             ZERO_LED,
	output logic             FILT_LED
);

	localparam int FW = 64;

	// Parameter checks
	generate
		if (NFUNC < 1 || NFUNC > 8) begin : g_bad_func
			$error("NFUNC must be 1 to 8");
		end
		if (NRANGE < 1 || NRANGE > 8) begin : g_bad_range
			$error("NRANGE must be 1 to 8");
		end
		if (BLINK_CYC < 1) begin : g_bad_blink
			$error("BLINK_CYC must be positive");
		end
	endgenerate

	// Power of ten lookup
	function automatic logic signed [FW-1:0] pow10(input logic [3:0] e);
		logic signed [FW-1:0] p;
		p = 64'sh1;
		for (int i = 0; i < 12; i++) begin
			if (i < int'(e)) begin
				p = p * 64'sh0A;
			end
		end
		return p;
	endfunction

	function automatic logic signed [FW-1:0] absv(
		input logic signed [FW-1:0] v);
		return (v < 0) ? -v : v;
	endfunction

	// State
	rzf_ctrl_t                  ctrl_reg;
	logic [6:0]                 fwgt_reg [NFUNC];
	logic [6:0]                 iwgt_reg;
	logic signed [FW-1:0]       base_reg [NFUNC];
	logic [NFUNC-1:0]           bvalid_reg;
	logic signed [FW-1:0]       zprog_reg;
	logic                       cap_pend_reg;
	logic signed [FW-1:0]       iavg_reg;
	logic signed [FW-1:0]       favg_reg;
	logic                       iavg_ok_reg;
	logic                       favg_ok_reg;
	logic [9:0]                 settle_reg;
	logic [8:0]                 fblink_reg;
	logic [31:0]                blink_div_reg;
	logic                       blink_reg;
	logic                       ovr_last_reg;
	logic [31:0]                result_last_reg;

	// Combinational datapath
	logic [3:0]                 res_e;
	logic [3:0]                 abs_e;
	logic signed [FW-1:0]       res_div;
	logic signed [FW-1:0]       fs_lim;
	logic signed [FW-1:0]       z_lim;
	logic signed [FW-1:0]       fwin;
	logic signed [FW-1:0]       iwin;
	logic signed [FW-1:0]       x_fx;
	logic signed [FW-1:0]       di;
	logic signed [FW-1:0]       iavg_next;
	logic signed [FW-1:0]       y_fx;
	logic signed [FW-1:0]       df;
	logic signed [FW-1:0]       favg_next;
	logic signed [FW-1:0]       disp;
	logic signed [FW-1:0]       base_cur;
	logic signed [FW-1:0]       result;
	logic                       int_act;
	logic                       fbreak;
	logic                       over_in;
	logic                       over_base;
	logic                       over_disp;
	logic                       zero_on;
	logic [6:0]                 fw_cur;
	logic [8:0]                 tc_sum;
	logic                       rd_hit;
	logic [31:0]                rd_data;
	logic                       apb_go;
	logic signed [FW-1:0]       zprog_cur;

	assign fw_cur = fwgt_reg[ctrl_reg.func];
	assign res_e  = {2'b00, ctrl_reg.res};
	assign abs_e  = res_e + {1'b0, ctrl_reg.range};
	assign res_div = pow10(res_e);
	assign int_act = ctrl_reg.ifilt && (ctrl_reg.res < 2'd2); // R20
	assign zero_on = bvalid_reg[ctrl_reg.func]; // R2

	// Limits scaled by resolution
	always_comb begin
		fs_lim = $signed({32'h0, RZF_FS_COUNTS}) / res_div;   // R6
		z_lim  = $signed({32'h0, RZF_ZLIM_COUNTS}) / res_div; // R5 R6
		fwin   = $signed({32'h0, RZF_FWIN_COUNTS}) / res_div; // R18
		iwin   = $signed({32'h0, RZF_IWIN_COUNTS}) / res_div;
	end

	// Internal exponential filter stage
	always_comb begin
		x_fx = $signed({{32{SAMPLE_DATA[31]}}, SAMPLE_DATA}) <<< RZF_FRAC; // R23
		di   = x_fx - iavg_reg;
		if (!iavg_ok_reg || absv(di) > (iwin <<< RZF_FRAC)) begin
			iavg_next = x_fx;
		end else begin
			iavg_next = iavg_reg + di / $signed({57'h0, iwgt_reg});
		end
		y_fx = int_act ? iavg_next : x_fx; // R20
	end

	// Front panel weighted average with window
	always_comb begin
		df     = y_fx - favg_reg;
		fbreak = favg_ok_reg && (absv(df) > (fwin <<< RZF_FRAC)); // R17
		if (!favg_ok_reg || fbreak) begin
			favg_next = y_fx; // R17
		end else begin
			favg_next = favg_reg + df / $signed({57'h0, fw_cur}); // R16
		end
		disp = (ctrl_reg.filt ? favg_next : y_fx) >>> RZF_FRAC;
	end

	// Baseline rescale, subtraction and overrange checks
	always_comb begin
		base_cur  = base_reg[ctrl_reg.func] / pow10(abs_e); // R3
		over_in   = SAMPLE_OVR ||
			absv($signed({{32{SAMPLE_DATA[31]}}, SAMPLE_DATA})) > fs_lim; // R7
		over_base = zero_on && (absv(base_cur) > fs_lim); // R8
		result    = zero_on ? (disp - base_cur) :
			(cap_pend_reg ? '0 : disp); // R1
		over_disp = absv(result) > (zero_on ? z_lim : fs_lim); // R5
	end

	// Settling time constant in readings
	always_comb begin
		tc_sum = 9'h0;
		if (ctrl_reg.filt) begin
			tc_sum = tc_sum + {2'b00, fw_cur};
		end
		if (int_act) begin
			tc_sum = tc_sum + {2'b00, iwgt_reg}; // R22
		end
	end

	// APB control register and internal filter weight
	assign apb_go = PSEL && PENABLE && !PREADY;

	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			ctrl_reg       <= '0;
			ctrl_reg.ifilt <= RZF_IFILT_RST; // R20
			iwgt_reg       <= RZF_IWGT_RST;
		end else if (apb_go && PWRITE) begin
			if (PADDR == RZF_OFS_CTRL) begin
				ctrl_reg <= PWDATA[14:0] & 15'h737F;
			end
			if (PADDR == RZF_OFS_IWGT && PWDATA[6:0] >= RZF_WGT_MIN &&
				PWDATA[6:0] <= RZF_WGT_MAX && PWDATA[31:7] == 25'h0) begin
				iwgt_reg <= PWDATA[6:0];
			end
		end
	end

	// Per-function front filter weights
	generate
		for (genvar f = 0; f < NFUNC; f++) begin : g_fwgt
			always_ff @(posedge REF_CLK) begin
				if (SRST) begin
					fwgt_reg[f] <= RZF_FWGT_RST; // R14
				end else if (apb_go && PWRITE && PADDR == RZF_OFS_FWGT &&
					int'(ctrl_reg.func) == f &&
					PWDATA[6:0] >= RZF_WGT_MIN &&
					PWDATA[6:0] <= RZF_WGT_MAX &&
					PWDATA[31:7] == 25'h0) begin
					fwgt_reg[f] <= PWDATA[6:0]; // R14 R15
				end
			end
		end
	endgenerate

	// Zero enable edges, capture and per-function baselines
	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			cap_pend_reg <= 1'b0;
			bvalid_reg   <= '0;
			zprog_reg    <= '0;
			for (int f = 0; f < NFUNC; f++) begin
				base_reg[f] <= '0;
			end
		end else begin
			if (apb_go && PWRITE && PADDR == RZF_OFS_CTRL) begin
				if (PWDATA[RZF_CTRL_ZERO] && !ctrl_reg.zero) begin
					cap_pend_reg <= 1'b1; // R9
				end
				if (!PWDATA[RZF_CTRL_ZERO] && ctrl_reg.zero) begin
					cap_pend_reg                <= 1'b0;
					bvalid_reg[ctrl_reg.func]   <= 1'b0; // R11
					base_reg[ctrl_reg.func]     <= '0;   // R11
				end
			end else if (apb_go && PWRITE && PADDR == RZF_OFS_ZPROG) begin
				zprog_reg <= $signed({{32{PWDATA[31]}}, PWDATA}) *
					pow10(abs_e);
			end else if (SAMPLE_VALID && cap_pend_reg && !over_in) begin
				cap_pend_reg              <= 1'b0; // R9 R12
				bvalid_reg[ctrl_reg.func] <= 1'b1;
				base_reg[ctrl_reg.func]   <= disp * pow10(abs_e); // R1 R3 R4
				zprog_reg                 <= disp * pow10(abs_e); // R10
			end
		end
	end

	// Filter state
	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			iavg_reg    <= '0;
			favg_reg    <= '0;
			iavg_ok_reg <= 1'b0;
			favg_ok_reg <= 1'b0;
		end else if (SAMPLE_VALID && !SAMPLE_OVR) begin
			iavg_reg    <= iavg_next;
			iavg_ok_reg <= int_act;
			favg_reg    <= favg_next;
			favg_ok_reg <= ctrl_reg.filt;
		end
	end

	// Settling and filter indicator counters, in readings
	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			settle_reg <= '0;
			fblink_reg <= '0;
		end else if (TRIG) begin
			settle_reg <= 10'(RZF_SETTLE_TC * int'(tc_sum)); // R21 R22
			fblink_reg <= ctrl_reg.filt ?
				9'(RZF_SETTLE_TC * int'(fw_cur)) : 9'h0; // R19
		end else if (SAMPLE_VALID) begin
			if (settle_reg != 10'h0) begin
				settle_reg <= settle_reg - 10'h1;
			end
			if (!ctrl_reg.single && ctrl_reg.filt && fbreak) begin
				fblink_reg <= {2'b00, fw_cur}; // R19
			end else if (fblink_reg != 9'h0) begin
				fblink_reg <= fblink_reg - 9'h1;
			end
		end
	end

	// Result output, withheld in single trigger mode while settling
	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			RES_VALID       <= 1'b0;
			RES_DATA        <= '0;
			ovr_last_reg    <= 1'b0;
			result_last_reg <= '0;
		end else begin
			RES_VALID <= 1'b0;
			if (SAMPLE_VALID &&
				!(ctrl_reg.single && settle_reg > 10'h1)) begin // R21
				RES_VALID          <= 1'b1;
				RES_DATA.value     <= result[31:0]; // R23
				RES_DATA.ovr       <= over_in || over_base ||
					over_disp; // R5 R7 R8
				RES_DATA.hazard    <= SAMPLE_HV; // R13
				ovr_last_reg       <= over_in || over_base || over_disp;
				result_last_reg    <= result[31:0];
			end
		end
	end

	// Blink rate enable divider
	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			blink_div_reg <= '0;
			blink_reg     <= 1'b0;
		end else if (blink_div_reg >= 32'(BLINK_CYC - 1)) begin
			blink_div_reg <= '0;
			blink_reg     <= !blink_reg;
		end else begin
			blink_div_reg <= blink_div_reg + 32'h1;
		end
	end

	// Indicator lamps
	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			ZERO_LED <= 1'b0;
			FILT_LED <= 1'b0;
		end else begin
			ZERO_LED <= cap_pend_reg ? blink_reg : zero_on; // R12
			FILT_LED <= ctrl_reg.filt &&
				((fblink_reg != 9'h0) ? blink_reg : 1'b1); // R19 R20
		end
	end

	// Read multiplexer
	assign zprog_cur = zprog_reg / pow10(abs_e);

	always_comb begin
		rd_hit  = 1'b1;
		rd_data = 32'h0;
		case (PADDR)
			RZF_OFS_CTRL:   rd_data = {17'h0, ctrl_reg};
			RZF_OFS_FWGT:   rd_data = {25'h0, fw_cur};
			RZF_OFS_IWGT:   rd_data = {25'h0, iwgt_reg};
			RZF_OFS_STAT:   rd_data = {26'h0, settle_reg == 10'h0,
				fblink_reg != 9'h0, ovr_last_reg, int_act, zero_on,
				cap_pend_reg};
			RZF_OFS_RESULT: rd_data = result_last_reg;
			RZF_OFS_BASE:   rd_data = base_cur[31:0];
			RZF_OFS_ZPROG:  rd_data = zprog_cur[31:0];
			default:        rd_hit  = 1'b0;
		endcase
	end

	// APB response, one wait state
	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			PREADY  <= 1'b0;
			PRDATA  <= 32'h0;
			PSLVERR <= 1'b0;
		end else begin
			PREADY  <= apb_go;
			PSLVERR <= apb_go && !rd_hit;
			if (apb_go && !PWRITE) begin
				PRDATA <= rd_hit ? rd_data : 32'h0;
			end
		end
	end

endmodule // rzf_top

// File: design/rzf_pkg.sv
// Purpose: Shared constants and types for the reading zero and filter block
// Assumes: One 40 MHz processing clock, APB register access
// Notes:   Offsets are byte addresses of 32-bit words
package rzf_pkg;

	// Register byte offsets
	localparam logic [7:0] RZF_OFS_CTRL   = 8'h00;
	localparam logic [7:0] RZF_OFS_FWGT   = 8'h04;
	localparam logic [7:0] RZF_OFS_IWGT   = 8'h08;
	localparam logic [7:0] RZF_OFS_STAT   = 8'h0C;
	localparam logic [7:0] RZF_OFS_RESULT = 8'h10;
	localparam logic [7:0] RZF_OFS_BASE   = 8'h14;
	localparam logic [7:0] RZF_OFS_ZPROG  = 8'h18;

	// Control field positions
	localparam int RZF_CTRL_ZERO   = 0;
	localparam int RZF_CTRL_FILT   = 1;
	localparam int RZF_CTRL_IFILT  = 2;
	localparam int RZF_CTRL_SINGLE = 3;
	localparam int RZF_CTRL_FUNC   = 4;
	localparam int RZF_CTRL_RES    = 8;
	localparam int RZF_CTRL_RANGE  = 12;

	// Reset values and weight limits
	localparam logic [6:0] RZF_FWGT_RST = 7'h0A;
	localparam logic [6:0] RZF_IWGT_RST = 7'h0A;
	localparam logic       RZF_IFILT_RST = 1'b1;
	localparam logic [6:0] RZF_WGT_MIN  = 7'h01;
	localparam logic [6:0] RZF_WGT_MAX  = 7'h63;

	// Count limits at the highest resolution, settling factor and fraction bits
	localparam logic [31:0] RZF_FS_COUNTS   = 32'h0021_91C0;
	localparam logic [31:0] RZF_ZLIM_COUNTS = 32'h0043_2380;
	localparam logic [31:0] RZF_FWIN_COUNTS = 32'h0000_2710;
	localparam logic [31:0] RZF_IWIN_COUNTS = 32'h0000_0014;
	localparam int          RZF_SETTLE_TC   = 3;
	localparam int          RZF_FRAC        = 8;

	// Blink timing
	localparam int RZF_CLK_HZ      = 40_000_000;
	localparam int RZF_BLINK_MS    = 250;
	localparam int RZF_BLINK_CYC   = RZF_CLK_HZ / 1000 * RZF_BLINK_MS;

	// Control register layout
	typedef struct packed {
		logic [2:0] range;
		logic [1:0] spare_hi;
		logic [1:0] res;
		logic       spare_lo;
		logic [2:0] func;
		logic       single;
		logic       ifilt;
		logic       filt;
		logic       zero;
	} rzf_ctrl_t;

	// Result carrier towards display and output path
	typedef struct packed {
		logic        ovr;
		logic        hazard;
		logic [31:0] value;
	} rzf_result_t;

endpackage : rzf_pkg

// File: tb/rzf_checker.sv
// Purpose: Port assertions for the reading zero and filter block
// Assumes: One REF_CLK domain, SRST synchronous and active high
// Notes:   Attached by bind to the top module
`timescale 1ns/1ps
module rzf_checker
	import rzf_pkg::*;
(
	input wire logic        REF_CLK,
	input wire logic        SRST,
	input wire logic        PSEL,
	input wire logic        PENABLE,
	input wire logic        PREADY,
	input wire logic        SAMPLE_VALID,
	input wire logic [31:0] SAMPLE_DATA,
	input wire logic        SAMPLE_OVR,
	input wire logic        SAMPLE_HV,
	input wire logic        RES_VALID,
	input wire rzf_result_t RES_DATA
);
	localparam int FS = 2200000;
	localparam int DMAX = 4400000;
	logic signed [31:0] in_s;
	logic signed [31:0] out_s;

	// Signed views of reading and result
	assign in_s = SAMPLE_DATA;
	assign out_s = RES_DATA.value;

	// All properties sample on REF_CLK and idle in reset
	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (SRST);

	// Bus answer timing
	a_apb_answer: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
		else $error("no ready after access");
	a_ready_pulse: assert property (PREADY |=> !PREADY)
		else $error("ready held too long");

	// Result timing and flags
	a_result_cause: assert property (RES_VALID |-> $past(SAMPLE_VALID))
		else $error("result without reading");
	a_hazard_mark: assert property (
		RES_VALID |-> RES_DATA.hazard == $past(SAMPLE_HV))
		else $error("hazard mark wrong");
	a_input_over: assert property (
		RES_VALID && $past(SAMPLE_OVR) |-> RES_DATA.ovr)
		else $error("front end overrange lost");
	a_full_scale: assert property (
		RES_VALID && ($past(in_s) > FS || $past(in_s) < -FS) |-> RES_DATA.ovr)
		else $error("input above full scale shown");
	a_display_cap: assert property (
		RES_VALID && !RES_DATA.ovr |-> out_s <= DMAX && out_s >= -DMAX)
		else $error("result beyond display range");
	a_result_hold: assert property (!RES_VALID |-> $stable(RES_DATA))
		else $error("result changed without valid");
endmodule // rzf_checker

bind rzf_top rzf_checker chk_u (.REF_CLK(REF_CLK), .SRST(SRST), .PSEL(PSEL),
	.PENABLE(PENABLE), .PREADY(PREADY), .SAMPLE_VALID(SAMPLE_VALID),
	.SAMPLE_DATA(SAMPLE_DATA), .SAMPLE_OVR(SAMPLE_OVR),
	.SAMPLE_HV(SAMPLE_HV), .RES_VALID(RES_VALID), .RES_DATA(RES_DATA));

// File: tb/rzf_frontend.sv
// Purpose: Behavioural model of the measurement front end
// Assumes: One request at a time, latency chosen by the bench
// Notes:   Idle data lines toggle so stale values never pass
`timescale 1ns/1ps
module rzf_frontend (
	input  wire logic        clk,
	input  wire logic        srst,
	input  wire logic        go,
	input  wire logic [1:0]  lat,
	input  wire logic [31:0] d_in,
	input  wire logic        ovr_in,
	input  wire logic        hv_in,
	output logic             valid,
	output logic [31:0]      data,
	output logic             ovr,
	output logic             hv
);
	logic        busy_reg;
	logic [1:0]  cnt_reg;
	logic [33:0] pend_reg;

	// One reading per request after lat idle cycles
	always_ff @(posedge clk) begin
		valid <= 1'b0;
		{ovr, hv, data} <= ~{ovr, hv, data};
		if (srst) begin
			busy_reg <= 1'b0;
			{ovr, hv, data} <= '0;
		end else if (go && !busy_reg) begin
			busy_reg <= 1'b1;
			cnt_reg <= lat;
			pend_reg <= {ovr_in, hv_in, d_in};
		end else if (busy_reg && cnt_reg != 2'h0) begin
			cnt_reg <= cnt_reg - 2'h1;
		end else if (busy_reg) begin
			busy_reg <= 1'b0;
			valid <= 1'b1;
			{ovr, hv, data} <= pend_reg;
		end
	end
endmodule // rzf_frontend

// File: tb/test_rzf_top.sv
// Purpose: Self-checking bench for the reading zero and filter block
// Assumes: 40 MHz REF_CLK, blink half period shortened to 4 clocks
// Notes:   Driver queues expected results, a monitor compares them
`timescale 1ns/1ps
module test_rzf_top;
	import rzf_pkg::*;
	logic        REF_CLK, SRST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
	logic        TRIG, SAMPLE_VALID, SAMPLE_OVR, SAMPLE_HV, RES_VALID;
	logic        ZERO_LED, FILT_LED, fe_go, fe_o, fe_h, qe;
	logic [7:0]  PADDR;
	logic [31:0] PWDATA, PRDATA, SAMPLE_DATA, fe_d, q, v;
	logic [15:0] lfsr;
	rzf_result_t RES_DATA;
	rzf_result_t exq[$];
	int          n_mismatch, samples_checked, i;

	// Device and front end model
	rzf_top #(.BLINK_CYC(4)) dut_u (.REF_CLK(REF_CLK), .SRST(SRST),
		.PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
		.PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
		.PSLVERR(PSLVERR), .TRIG(TRIG), .SAMPLE_VALID(SAMPLE_VALID),
		.SAMPLE_DATA(SAMPLE_DATA), .SAMPLE_OVR(SAMPLE_OVR),
		.SAMPLE_HV(SAMPLE_HV), .RES_VALID(RES_VALID),
		.RES_DATA(RES_DATA), .ZERO_LED(ZERO_LED), .FILT_LED(FILT_LED));
	rzf_frontend fe_u (.clk(REF_CLK), .srst(SRST), .go(fe_go),
		.lat(lfsr[1:0]), .d_in(fe_d), .ovr_in(fe_o), .hv_in(fe_h),
		.valid(SAMPLE_VALID), .data(SAMPLE_DATA), .ovr(SAMPLE_OVR),
		.hv(SAMPLE_HV));

	// Clock
	initial begin
		REF_CLK = 1'b0;
		forever #12.5 REF_CLK = ~REF_CLK;
	end

	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	task automatic fail(input string m);
		n_mismatch++;
		$display("wrong value at %0t: %s", $time, m);
	endtask

	task automatic chk32(input logic [31:0] g, e);
		samples_checked++;
		if (g !== e)
			fail($sformatf("got %h want %h", g, e));
	endtask

	task automatic chk_res(input rzf_result_t e, g);
		samples_checked++;
		if (g.ovr !== e.ovr || g.hazard !== e.hazard
			|| (!e.ovr && g.value !== e.value))
			fail($sformatf("result %h want %h", g, e));
	endtask

	// One APB transfer, waits for the answer
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge REF_CLK);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge REF_CLK);
		PENABLE <= 1'b1;
		do begin
			@(posedge REF_CLK);
			n++;
		end while (PREADY !== 1'b1 && n < 40);
		if (n >= 40)
			fail("no bus answer");
		q = PRDATA;
		qe = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk32(q, e);
	endtask

	task automatic ctl(input logic [31:0] d);
		apb(1'b1, RZF_OFS_CTRL, d);
	endtask

	// Reading request; k 0 withheld, 1 exact value, 2 overrange
	task automatic rdg(input logic [31:0] d, e, input logic o, h, input int k);
		int n;
		if (k > 0)
			exq.push_back('{ovr: k == 2, hazard: h, value: e});
		lfsr = lfsr_next(lfsr);
		@(posedge REF_CLK);
		fe_go <= 1'b1;
		fe_d <= d;
		fe_o <= o;
		fe_h <= h;
		@(posedge REF_CLK);
		fe_go <= 1'b0;
		n = 0;
		while (SAMPLE_VALID !== 1'b1 && n < 20) begin
			@(posedge REF_CLK);
			n++;
		end
		repeat (2) @(posedge REF_CLK);
	endtask

	// Indicator watch: bit 1 seen lit, bit 0 seen dark
	task automatic led(input logic z, input logic [31:0] e);
		logic [31:0] s;
		s = 0;
		repeat (12) begin
			@(negedge REF_CLK);
			if ((z ? ZERO_LED : FILT_LED) === 1'b1)
				s[1] = 1'b1;
			else
				s[0] = 1'b1;
		end
		chk32(s, e);
	endtask

	task automatic pulse();
		@(posedge REF_CLK);
		TRIG <= 1'b1;
		@(posedge REF_CLK);
		TRIG <= 1'b0;
	endtask

	task automatic complete_run();
		$display("checked %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Result monitor
	always @(negedge REF_CLK) begin
		if (SRST === 1'b0 && RES_VALID === 1'b1) begin
			if (exq.size() == 0)
				fail("unexpected result");
			else
				chk_res(exq.pop_front(), RES_DATA);
		end
	end

	// Watchdog
	initial begin
		#2000000;
		fail("timeout");
		complete_run();
	end

	// Main sequence
	initial begin
		{SRST, PSEL, PENABLE, PWRITE, TRIG, fe_go, fe_o, fe_h} = 8'h80;
		{PADDR, PWDATA, fe_d} = '0;
		lfsr = 16'h005E;
		repeat (3) @(posedge REF_CLK);
		SRST <= 1'b0;
		rd(RZF_OFS_CTRL, 32'h4);
		rd(RZF_OFS_FWGT, 32'hA);
		rd(RZF_OFS_IWGT, 32'hA);
		apb(1'b0, 8'h1C, 32'h0);
		chk32({31'h0, qe}, 32'h1);
		ctl(32'h0);
		for (i = 0; i < 8; i++) begin
			lfsr = lfsr_next(lfsr);
			v = 32'($signed(lfsr) * 33);
			rdg(v, v, 1'b0, lfsr[0], 1);
		end
		rdg(32'd2200000, 32'd2200000, 1'b0, 1'b0, 1);
		rdg(32'd1000, 0, 1'b1, 1'b0, 2);
		ctl(32'h300);
		rdg(32'd2200, 32'd2200, 1'b0, 1'b1, 1);
		rdg(32'd2201, 0, 1'b0, 1'b0, 2);
		ctl(32'h1001);
		led(1'b1, 32'h3);
		rdg(-32'sd2200000, 0, 1'b0, 1'b0, 1);
		led(1'b1, 32'h2);
		rdg(32'd2200000, 32'd4400000, 1'b0, 1'b0, 1);
		rdg(32'd2200001, 0, 1'b0, 1'b0, 2);
		rd(RZF_OFS_BASE, -32'sd2200000);
		rd(RZF_OFS_ZPROG, -32'sd2200000);
		ctl(32'h1011);
		rdg(32'd500, 32'd500, 1'b0, 1'b0, 1);
		ctl(32'h1);
		rdg(32'd0, 0, 1'b0, 1'b0, 2);
		ctl(32'h2001);
		rdg(32'd0, 32'd220000, 1'b0, 1'b0, 1);
		ctl(32'h1000);
		rd(RZF_OFS_BASE, 32'h0);
		rd(RZF_OFS_ZPROG, -32'sd2200000);
		ctl(32'h2);
		apb(1'b1, RZF_OFS_FWGT, 32'd4);
		apb(1'b1, RZF_OFS_FWGT, 32'd0);
		apb(1'b1, RZF_OFS_FWGT, 32'd100);
		rd(RZF_OFS_FWGT, 32'd4);
		rdg(32'd100000, 32'd100000, 1'b0, 1'b0, 1);
		rdg(32'd100400, 32'd100100, 1'b0, 1'b0, 1);
		rdg(32'd100500, 32'd100200, 1'b0, 1'b0, 1);
		led(1'b0, 32'h2);
		rdg(32'd120000, 32'd120000, 1'b0, 1'b0, 1);
		led(1'b0, 32'h3);
		rdg(32'd130000, 32'd122500, 1'b0, 1'b0, 1);
		ctl(32'h22);
		apb(1'b1, RZF_OFS_FWGT, 32'd20);
		ctl(32'hA);
		rd(RZF_OFS_FWGT, 32'd4);
		pulse();
		led(1'b0, 32'h3);
		for (i = 0; i < 11; i++)
			rdg(32'd122500, 0, 1'b0, 1'b0, 0);
		rdg(32'd122500, 32'd122500, 1'b0, 1'b0, 1);
		ctl(32'h2);
		for (i = 0; i < 3; i++)
			rdg(32'd122500, 32'd122500, 1'b0, 1'b0, 1);
		ctl(32'h104);
		apb(1'b0, RZF_OFS_STAT, 32'h0);
		chk32({31'h0, q[2]}, 32'h1);
		rdg(32'd1000, 32'd1000, 1'b0, 1'b0, 1);
		rdg(32'd1001, 32'd1000, 1'b0, 1'b0, 1);
		pulse();
		led(1'b0, 32'h1);
		ctl(32'h204);
		apb(1'b0, RZF_OFS_STAT, 32'h0);
		chk32({31'h0, q[2]}, 32'h0);
		chk32(32'(exq.size()), 32'h0);
		complete_run();
	end
endmodule // test_rzf_top
